// ---- pwm_bridge_pkg.sv ----
package pwm_bridge_pkg;

  // ==========================================================================
  // Register map (byte addresses of 32-bit words, data in the low byte; timer count reads back in bits 15:8)
  // ==========================================================================
  localparam logic [7:0] OFS_DEADBAND_RESTART = 8'h00;
  localparam logic [7:0] OFS_SHUTDOWN_CONTROL = 8'h04;
  localparam logic [7:0] OFS_MODE_CONTROL = 8'h08;
  localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h0c;
  localparam logic [7:0] OFS_DUTY = 8'h10;
  localparam logic [7:0] OFS_TIMER_CONTROL = 8'h14;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_DEADBAND_RESTART = 8'h00;
  localparam logic [7:0] RST_SHUTDOWN_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE_CONTROL = 8'h00;
  localparam logic [7:0] RST_PERIOD_LIMIT = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_TIMER_CONTROL = 8'h00;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int RESTART_ENABLE_BIT = 7;
  localparam int DEADBAND_COUNT_MSB = 6;
  localparam int SHUTDOWN_STATUS_BIT = 7;
  localparam int SOURCE_SELECT_MSB = 6;
  localparam int SOURCE_SELECT_LSB = 4;
  localparam int PAIR_AC_MSB = 3;
  localparam int PAIR_AC_LSB = 2;
  localparam int PAIR_BD_MSB = 1;
  localparam int PAIR_BD_LSB = 0;
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int DIRECTION_BIT = 7;
  localparam int PRESCALE_MSB = 1;
  localparam int PRESCALE_LSB = 0;
  localparam int TIMER_ON_BIT = 2;
  localparam int COUNT_READ_LSB = 8;

  // ==========================================================================
  // Timing: one instruction cycle is four oscillator periods
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 4;
  localparam int INSTR_CYCLE_NS = 4;
  localparam int CLKS_PER_INSTR = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
  localparam logic [4:0] PRESCALE_1 = 5'h01;
  localparam logic [4:0] PRESCALE_4 = 5'h04;
  localparam logic [4:0] PRESCALE_16 = 5'h10;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_HALF,
    MODE_FULL_FWD,
    MODE_FULL_REV
  } bridge_mode_t;

  // Four bridge pins: value and output enable, index 0..3 = A..D
  typedef struct packed {
    logic [3:0] level;
    logic [3:0] enable;
  } bridge_pins_t;

  typedef struct packed {
    logic cmp1;
    logic cmp2;
    logic faultN;
  } fault_inputs_t;

endpackage : pwm_bridge_pkg

// ---- bridge_pwm_steering_shutdown.sv ----
// Overview of operation
// - Full bridge drives at most two of four outputs active at once.
// - Forward: A held active, D modulated, B and C inactive.
// - Reverse: C held active, B modulated, A and D inactive.
// - Direction bit written anytime takes effect from the next PWM cycle.
// - One prescaled tick before period end, A/C switch; B/D forced inactive.
// - No dead-band delay at all in full-bridge mode.
// - Half bridge delays only inactive-to-active edges by the dead-band.
// - Seven-bit dead-band count in instruction cycles of four oscillator periods.
// - Shutdown event forces outputs to shutdown levels immediately.
// - Three-bit source select picks comparators and fault pin combinations.
// - Fault input is active low when selected.
// - A/C shutdown state: 00 low, 01 high, 1x high impedance.
// - B/D shutdown state: 00 low, 01 high, 1x high impedance.
// - Hardware sets shutdown status on an event; outputs held while set.
// - With restart enabled, status clears itself once the cause is gone.
// - With restart disabled, status stays set until software writes zero.
// - Status set at period start keeps outputs shut that whole period.
// - After status clears, normal drive resumes at next period start.
// - Writes to the status bit ignored while a selected condition persists.
// - Period boundary is the increment after count equals the limit.
// - Comparator shutdown is a level; status cannot clear while it persists.
// - Software writing one to status forces shutdown like a hardware event.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module bridge_pwm_steering_shutdown (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pwm_bridge_pkg::fault_inputs_t faultInputs,
  output pwm_bridge_pkg::bridge_pins_t bridgePins
);
  import pwm_bridge_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] deadbandRestartReg;
    logic [6:0] shutdownControlReg;
    logic shutdownStatus;
    logic [7:0] pwmModeControl;
    logic [7:0] periodLimit;
    logic [7:0] duty;
    logic [7:0] timerControl;
    logic [3:0] prescaleCount;
    logic [7:0] periodTimerCount;
    logic [7:0] dutyLatch;
    bridge_mode_t activeMode;
    logic suppressed;
    logic periodBegun;
    logic [1:0] rawPrev;
    logic [6:0] dbCountA;
    logic [6:0] dbCountB;
    logic [3:0] pinNormal;
  } state_t;

  state_t state;
  state_t next_state;

  // ==========================================================================
  // Helper functions
  // ==========================================================================
  // Last prescaler count for the 1, 4 or 16 divide settings
  function automatic logic [3:0] prescaleLast(input logic [1:0] sel);
    logic [4:0] div;
    div = PRESCALE_1;
    case (sel)
      2'h0: div = PRESCALE_1;
      2'h1: div = PRESCALE_4;
      default: div = PRESCALE_16;
    endcase
    prescaleLast = 4'(div - 5'h01);
  endfunction : prescaleLast

  function automatic bridge_mode_t decodeMode(input logic [1:0] field);
    bridge_mode_t m;
    m = MODE_SINGLE;
    case (field)
      2'h0: m = MODE_SINGLE;
      2'h2: m = MODE_HALF;
      2'h1: m = MODE_FULL_FWD;
      default: m = MODE_FULL_REV;
    endcase
    decodeMode = m;
  endfunction : decodeMode

  // Dead-band step: returns {active, next count}
  function automatic logic [7:0] deadbandStep(input logic raw,
                                              input logic prev,
                                              input logic [6:0] cnt,
                                              input logic [6:0] load);
    logic [6:0] eff;
    eff = (raw && !prev) ? load : cnt;
    if (!raw) begin
      deadbandStep = {1'b0, 7'h00};
    end else if (eff == 7'h00) begin
      deadbandStep = {1'b1, 7'h00};
    end else begin
      deadbandStep = {1'b0, 7'(eff - 7'h01)};
    end
  endfunction : deadbandStep

  // Shutdown pair level: {level, enable}
  function automatic logic [1:0] pairLevel(input logic [1:0] field);
    logic [1:0] r;
    r = 2'h1;
    case (field)
      2'h0: r = 2'h1;
      2'h1: r = 2'h3;
      default: r = 2'h0;
    endcase
    pairLevel = r;
  endfunction : pairLevel

  // ==========================================================================
  // Combinational decode of bus, timer, sources and drive
  // ==========================================================================
  logic busReq;
  logic wrStrobe;
  logic faultActive;
  logic [2:0] sourceSelect;
  logic conditionNow;
  logic wrStatusOne;
  logic wrStatusZero;
  logic prescaleTick;
  logic lastWindow;
  logic periodStart;
  bridge_mode_t pendingMode;
  logic steerEarly;
  logic pwmOn;
  logic [7:0] stepA;
  logic [7:0] stepB;
  logic [3:0] driveNormal;
  logic shutdownOut;
  logic [1:0] acLevel;
  logic [1:0] bdLevel;

  // Sources are levels; fault pin counts when low
  always_comb begin
    sourceSelect = state.shutdownControlReg[SOURCE_SELECT_MSB:SOURCE_SELECT_LSB];
    faultActive = !faultInputs.faultN;
    conditionNow = (sourceSelect[0] && faultInputs.cmp1) ||
                   (sourceSelect[1] && faultInputs.cmp2) ||
                   (sourceSelect[2] && faultActive);
    busReq = wb_cyc_i && wb_stb_i;
    wrStrobe = busReq && state.ack && wb_we_i && wb_sel_i[0];
    wrStatusOne = wrStrobe && (wb_adr_i == OFS_SHUTDOWN_CONTROL) &&
                  wb_dat_i[SHUTDOWN_STATUS_BIT];
    wrStatusZero = wrStrobe && (wb_adr_i == OFS_SHUTDOWN_CONTROL) &&
                   !wb_dat_i[SHUTDOWN_STATUS_BIT];
  end

  // Timer time base: one clock per instruction cycle, then prescaler
  always_comb begin
    prescaleTick = state.timerControl[TIMER_ON_BIT] &&
      (state.prescaleCount ==
       prescaleLast(state.timerControl[PRESCALE_MSB:PRESCALE_LSB]));
    lastWindow = state.timerControl[TIMER_ON_BIT] &&
                 (state.periodTimerCount == state.periodLimit);
    periodStart = prescaleTick && lastWindow;
    pendingMode = decodeMode(state.pwmModeControl[MODE_MSB:MODE_LSB]);
    // Early swap only between the two full-bridge directions
    steerEarly = lastWindow &&
                 ((state.activeMode == MODE_FULL_FWD &&
                   pendingMode == MODE_FULL_REV) ||
                  (state.activeMode == MODE_FULL_REV &&
                   pendingMode == MODE_FULL_FWD));
    pwmOn = state.periodTimerCount < state.dutyLatch;
  end

  // Normal drive pattern, index 0..3 = A..D
  always_comb begin
    stepA = deadbandStep(pwmOn, state.rawPrev[0], state.dbCountA,
                         state.deadbandRestartReg[DEADBAND_COUNT_MSB:0]);
    stepB = deadbandStep(!pwmOn, state.rawPrev[1], state.dbCountB,
                         state.deadbandRestartReg[DEADBAND_COUNT_MSB:0]);
    driveNormal = 4'h0;
    case (state.activeMode)
      MODE_SINGLE: driveNormal = {3'h0, pwmOn};
      // Only the rising edge of each output is held back
      MODE_HALF: driveNormal = {2'h0, stepB[7], stepA[7]};
      // No dead-band path here: modulation passes straight through
      MODE_FULL_FWD: driveNormal = {pwmOn, 2'h0, 1'b1};
      MODE_FULL_REV: driveNormal = {1'b0, 1'b1, pwmOn, 1'b0};
      default: driveNormal = 4'h0;
    endcase
    if (steerEarly) begin
      // New direction on A/C, modulated pair parked inactive
      driveNormal = (pendingMode == MODE_FULL_REV) ? 4'h4 : 4'h1;
    end
  end

  // ==========================================================================
  // Next-state logic
  // ==========================================================================
  always_comb begin
    next_state = state;
    next_state.ack = busReq && !state.ack;
    next_state.rdata = 32'h0;
    if (busReq && !state.ack && !wb_we_i) begin
      case (wb_adr_i)
        OFS_DEADBAND_RESTART: next_state.rdata = {24'h0,
                                                  state.deadbandRestartReg};
        OFS_SHUTDOWN_CONTROL: next_state.rdata = {24'h0,
          state.shutdownStatus, state.shutdownControlReg};
        OFS_MODE_CONTROL: next_state.rdata = {24'h0, state.pwmModeControl};
        OFS_PERIOD_LIMIT: next_state.rdata = {24'h0, state.periodLimit};
        OFS_DUTY: next_state.rdata = {24'h0, state.duty};
        OFS_TIMER_CONTROL: next_state.rdata = {16'h0, state.periodTimerCount,
                                               state.timerControl};
        default: next_state.rdata = 32'h0;
      endcase
    end
    // Writes land on the edge where the master sees ack
    if (wrStrobe) begin
      case (wb_adr_i)
        OFS_DEADBAND_RESTART: next_state.deadbandRestartReg = wb_dat_i[7:0];
        OFS_SHUTDOWN_CONTROL: next_state.shutdownControlReg = wb_dat_i[6:0];
        // Taken anytime; copied to activeMode at the boundary, a new direction shows on A/C one prescaled tick before it
        OFS_MODE_CONTROL: next_state.pwmModeControl = wb_dat_i[7:0];
        OFS_PERIOD_LIMIT: next_state.periodLimit = wb_dat_i[7:0];
        OFS_DUTY: next_state.duty = wb_dat_i[7:0];
        OFS_TIMER_CONTROL: next_state.timerControl = {5'h0, wb_dat_i[2:0]};
        default: next_state.duty = state.duty;
      endcase
    end
    // Status: set wins over any clear; clears blocked by a live condition
    if (conditionNow || wrStatusOne) begin
      next_state.shutdownStatus = 1'b1;
    end else if (state.deadbandRestartReg[RESTART_ENABLE_BIT]) begin
      next_state.shutdownStatus = 1'b0;
    end else if (wrStatusZero) begin
      next_state.shutdownStatus = 1'b0;
    end
    // Timer and period boundary
    if (!state.timerControl[TIMER_ON_BIT] || prescaleTick) begin
      next_state.prescaleCount = 4'h0;
    end else begin
      next_state.prescaleCount = 4'(state.prescaleCount + 4'h1);
    end
    if (periodStart) begin
      next_state.periodTimerCount = 8'h0;
      next_state.dutyLatch = state.duty;
      next_state.activeMode = pendingMode;
    end else if (prescaleTick) begin
      next_state.periodTimerCount = 8'(state.periodTimerCount + 8'h01);
    end
    // Pins lag the timer by a clock; releasing at the wrap itself would
    // show the last slot of the old period on the pins
    next_state.periodBegun = periodStart;
    if (state.periodBegun) begin
      next_state.suppressed = state.shutdownStatus;
    end
    if (state.shutdownStatus) begin
      next_state.suppressed = 1'b1;
    end
    next_state.rawPrev = {!pwmOn, pwmOn};
    next_state.dbCountA = stepA[6:0];
    next_state.dbCountB = stepB[6:0];
    next_state.pinNormal = driveNormal;
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
      state.deadbandRestartReg <= RST_DEADBAND_RESTART;
      state.shutdownControlReg <= RST_SHUTDOWN_CONTROL[6:0];
      state.shutdownStatus <= RST_SHUTDOWN_CONTROL[SHUTDOWN_STATUS_BIT];
      state.pwmModeControl <= RST_MODE_CONTROL;
      state.periodLimit <= RST_PERIOD_LIMIT;
      state.duty <= RST_DUTY;
      state.timerControl <= RST_TIMER_CONTROL;
      state.activeMode <= MODE_SINGLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Live condition bypasses the flops so a fault acts without a clock edge
  always_comb begin
    shutdownOut = conditionNow || state.shutdownStatus || state.suppressed;
    acLevel = pairLevel(state.shutdownControlReg[PAIR_AC_MSB:PAIR_AC_LSB]);
    bdLevel = pairLevel(state.shutdownControlReg[PAIR_BD_MSB:PAIR_BD_LSB]);
    wb_ack_o = state.ack;
    wb_dat_o = state.rdata;
    if (shutdownOut) begin
      bridgePins.level = {bdLevel[1], acLevel[1], bdLevel[1], acLevel[1]};
      bridgePins.enable = {bdLevel[0], acLevel[0], bdLevel[0],
                           acLevel[0]};
    end else begin
      bridgePins.level = state.pinNormal;
      bridgePins.enable = 4'hf;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic isFull;
  assign isFull = (state.activeMode == MODE_FULL_FWD) ||
                  (state.activeMode == MODE_FULL_REV);

  full_two_active_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    isFull && !shutdownOut |-> $countones(bridgePins.level) <= 2)
    else $error("more than two bridge outputs active");

  forward_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.activeMode == MODE_FULL_FWD && !steerEarly
    |=> (state.pinNormal[2:0] == 3'h1))
    else $error("forward drive pattern wrong");

  reverse_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.activeMode == MODE_FULL_REV && !steerEarly
    |=> (state.pinNormal[0] == 1'b0 && state.pinNormal[3:2] == 2'h1))
    else $error("reverse drive pattern wrong");

  direction_deferred_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(state.activeMode) |-> $past(periodStart))
    else $error("mode changed off the period boundary");

  early_steer_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    steerEarly |=> state.pinNormal[3] == 1'b0 && state.pinNormal[1] == 1'b0
      && (state.pinNormal[0] ^ state.pinNormal[2]))
    else $error("direction swap pattern wrong");

  full_no_deadband_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.activeMode == MODE_FULL_FWD && !steerEarly
    |=> state.pinNormal[3] == $past(pwmOn))
    else $error("delay seen in full bridge");

  half_fall_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.activeMode == MODE_HALF && !pwmOn |=> !state.pinNormal[0])
    else $error("falling edge of output A delayed");

  half_delay_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.activeMode == MODE_HALF && pwmOn && !state.rawPrev[0] &&
    state.deadbandRestartReg[6:0] == 7'h02 ##1 pwmOn
    |=> !state.pinNormal[0])
    else $error("dead-band shorter than programmed");

  shut_immediate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    conditionNow |-> bridgePins.enable[0] == acLevel[0] &&
      bridgePins.level[3] == bdLevel[1])
    else $error("outputs not in shutdown state");

  status_set_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    conditionNow |=> state.shutdownStatus)
    else $error("status not set by event");

  write_ignored_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    conditionNow && wrStatusZero |=> state.shutdownStatus)
    else $error("status cleared during condition");

  auto_restart_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    state.deadbandRestartReg[RESTART_ENABLE_BIT] && !conditionNow &&
    !wrStatusOne && state.shutdownStatus |=> !state.shutdownStatus)
    else $error("auto restart did not clear status");

  manual_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !state.deadbandRestartReg[RESTART_ENABLE_BIT] && state.shutdownStatus &&
    !wrStatusZero |=> state.shutdownStatus)
    else $error("status cleared without write");

  resume_boundary_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(state.suppressed) |-> $past(state.periodBegun) &&
      !$past(state.shutdownStatus))
    else $error("resumed mid period");

endmodule : bridge_pwm_steering_shutdown

// ---- bridge_load_model.sv ----
`timescale 1ns/100ps
// ====================
// Power bridge at the pins
// ====================
module bridge_load_model (
  input wire pwm_bridge_pkg::bridge_pins_t bridgePins,
  output logic [3:0] gate,
  output logic shootThrough
);
  import pwm_bridge_pkg::*;

  // Gate pull-downs keep a switch off while its pin floats
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gate[i] = bridgePins.enable[i] ? bridgePins.level[i] : 1'b0;
    end
  end

  // A/B and C/D share a leg; both on shorts the supply
  assign shootThrough = (gate[0] & gate[1]) | (gate[2] & gate[3]);
endmodule : bridge_load_model

// ---- bridge_pwm_steering_shutdown_tb.sv ----
`timescale 1ns/100ps
module bridge_pwm_steering_shutdown_tb;
  import pwm_bridge_pkg::*;
  logic sysClk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, ack, shoot;
  logic [7:0] adr = 8'h00, q;
  logic [31:0] wdat = 32'h0, rdat;
  fault_inputs_t fin = 3'b001;
  bridge_pins_t pins;
  logic [3:0] gate;
  int nErrors = 0, samplesChecked = 0, cycles = 0, c[6];

  // ====================
  // Block and bridge
  // ====================
  bridge_pwm_steering_shutdown dut_u (.sys_clk(sysClk), .rstn(rstn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .faultInputs(fin), .bridgePins(pins));
  bridge_load_model load_u (.bridgePins(pins), .gate(gate),
    .shootThrough(shoot));

  // Clock and hang guard
  initial begin
    forever #2 sysClk = ~sysClk;
  end
  always @(posedge sysClk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      nErrors++;
      results();
    end
  end

  // ====================
  // Helpers
  // ====================
  task automatic results();
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] s, e);
    samplesChecked++;
    if (s !== e) begin
      nErrors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // Classic cycle; request held until ack is seen
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge sysClk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    // No local limit: only the hang guard ends a wait
    do begin
      @(posedge sysClk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge sysClk);
    #1;
  endtask : tick

  // Whole periods only, so the phase does not matter
  task automatic tally(input int n, input int a, b, e, f);
    c = '{default: 0};
    repeat (n) begin
      tick(1);
      for (int i = 0; i < 4; i++) c[i] += gate[i];
      c[4] += shoot;
      c[5] += ($countones(gate) > 2);
    end
    chk("pinA", c[0], a);
    chk("pinB", c[1], b);
    chk("pinC", c[2], e);
    chk("pinD", c[3], f);
    chk("shoot", c[4], 0);
    chk("overTwo", c[5], 0);
  endtask : tally

  // ====================
  // Scenarios
  // ====================
  task automatic regs();
    bus(0, OFS_DEADBAND_RESTART, 0);
    chk("dbReset", q, RST_DEADBAND_RESTART);
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("sdReset", q, RST_SHUTDOWN_CONTROL);
    bus(0, 8'h40, 0);
    chk("unmapped", q, 8'h00);
  endtask : regs

  // Dead-band set on purpose: full bridge must ignore it
  task automatic steady();
    bus(1, OFS_DEADBAND_RESTART, 8'h03);
    bus(1, OFS_MODE_CONTROL, 8'h40);
    tick(24);
    tally(32, 32, 0, 0, 12);
    bus(1, OFS_MODE_CONTROL, 8'hc0);
    tick(24);
    tally(32, 0, 12, 32, 0);
  endtask : steady

  task automatic deadband();
    int db[3] = '{0, 2, 5};
    bus(1, OFS_PERIOD_LIMIT, 8'h09);
    bus(1, OFS_DUTY, 8'h04);
    bus(1, OFS_MODE_CONTROL, 8'h80);
    foreach (db[i]) begin
      bus(1, OFS_DEADBAND_RESTART, 8'(db[i]));
      tick(30);
      tally(40, db[i] < 4 ? 16 - 4 * db[i] : 0, 24 - 4 * db[i], 0, 0);
    end
    bus(1, OFS_PERIOD_LIMIT, 8'h07);
    bus(1, OFS_DUTY, 8'h03);
  endtask : deadband

  // Duty 3 of 8 is far from full, so reversing is safe
  task automatic direction();
    int t, w, pv;
    for (int p = 0; p < 3; p++) begin
      pv = 1 << (2 * p);
      bus(1, OFS_TIMER_CONTROL, 8'h04 | 8'(p));
      bus(1, OFS_MODE_CONTROL, 8'h40);
      tick(24 * pv);
      t = 0;
      while (gate[3] !== 1'b0 && t < 400) begin
        tick(1);
        t++;
      end
      while (gate[3] !== 1'b1 && t < 400) begin
        tick(1);
        t++;
      end
      bus(1, OFS_MODE_CONTROL, 8'hc0);
      #1;
      chk("fwdHeld", gate[0], 1'b1);
      t = 0;
      while (gate[2] !== 1'b1 && t < 400) begin
        tick(1);
        t++;
      end
      chk("swapLate", t > pv, 1'b1);
      chk("swap", gate, 4'h4);
      w = 0;
      while (gate === 4'h4 && w < 99) begin
        tick(1);
        w++;
      end
      chk("window", w, pv);
      chk("revStart", gate, 4'h6);
    end
    bus(1, OFS_TIMER_CONTROL, 8'h04);
  endtask : direction

  // Each source code against each input; A/C float, B/D high
  task automatic sources();
    logic e;
    bus(1, OFS_DEADBAND_RESTART, 8'h00);
    bus(1, OFS_MODE_CONTROL, 8'h40);
    for (int s = 0; s < 8; s++) begin
      for (int k = 0; k < 3; k++) begin
        bus(1, OFS_SHUTDOWN_CONTROL, {1'b0, 3'(s), 4'h9});
        tick(20);
        @(posedge sysClk);
        fin <= {k == 0, k == 1, k != 2};
        #1;
        e = s[k];
        chk("shutB", gate[1], e);
        chk("floatA", pins.enable[0], !e);
        @(posedge sysClk);
        fin <= 3'b001;
      end
    end
  endtask : sources

  task automatic status();
    int t;
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h41);
    @(posedge sysClk);
    fin.faultN <= 1'b0;
    @(posedge sysClk);
    fin.faultN <= 1'b1;
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("latched", q, 8'hc1);
    @(posedge sysClk);
    fin.faultN <= 1'b0;
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h41);
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("wrWhileLive", q, 8'hc1);
    @(posedge sysClk);
    fin.faultN <= 1'b1;
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h41);
    t = 0;
    while (gate[0] !== 1'b1 && t < 99) begin
      tick(1);
      t++;
    end
    chk("resumeAtStart", gate[3], 1'b1);
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("cleared", q, 8'h41);
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h81);
    #1;
    chk("forced", gate, 4'ha);
    bus(1, OFS_DEADBAND_RESTART, 8'h80);
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h11);
    @(posedge sysClk);
    fin.cmp1 <= 1'b1;
    bus(1, OFS_SHUTDOWN_CONTROL, 8'h11);
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("levelHeld", q, 8'h91);
    @(posedge sysClk);
    fin.cmp1 <= 1'b0;
    tick(3);
    bus(0, OFS_SHUTDOWN_CONTROL, 0);
    chk("autoClear", q, 8'h11);
  endtask : status

  // Main sequence; timer runs period 8, duty 3, prescale 1
  initial begin
    repeat (16) @(posedge sysClk);
    rstn <= 1'b1;
    regs();
    bus(1, OFS_PERIOD_LIMIT, 8'h07);
    bus(1, OFS_DUTY, 8'h03);
    bus(1, OFS_TIMER_CONTROL, 8'h04);
    steady();
    deadband();
    direction();
    sources();
    status();
    results();
  end
endmodule : bridge_pwm_steering_shutdown_tb
